// ===== hw/irq_ctrl_pkg.sv
// constants for the vectored interrupt controller: register map,
// reset values, source layout and vector table
// assumes an 8-bit register port with 16-bit addresses
package irq_ctrl_pkg;

	localparam int NUM_SRC = 11;
	localparam int IDX_W   = 4;

	// register addresses
	localparam logic [15:0] ADDR_PEND_LO  = 16'hFFE0;
	localparam logic [15:0] ADDR_PEND_HI  = 16'hFFE1;
	localparam logic [15:0] ADDR_DIS_LO   = 16'hFFE4;
	localparam logic [15:0] ADDR_DIS_HI   = 16'hFFE5;
	localparam logic [15:0] ADDR_EDGE_SEL = 16'hFFEC;

	// reset values
	localparam logic [7:0] PEND_RESET = 8'h00;
	localparam logic [7:0] DIS_RESET  = 8'hFF;
	localparam logic [1:0] EDGE_RESET = 2'h0;

	// implemented bit positions; others are fixed
	localparam logic [7:0] LO_USED = 8'hF3;
	localparam logic [7:0] HI_USED = 8'h7C;

	// edge select field in the edge select register
	localparam int EDGE_LSB = 2;
	typedef enum logic [1:0] {
		EDGE_FALL = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_BAD  = 2'h2,
		EDGE_BOTH = 2'h3
	} edge_sel_t;

	// source index equals fixed priority, 0 highest
	localparam int SRC_WDT = 0;
	localparam int SRC_PIN = 6;
	localparam int SRC_SER = 7;

	// which register each source lives in (1 = high) and its bit
	localparam logic [NUM_SRC-1:0] SRC_IN_HI = 11'h03E;
	localparam int SRC_POS [NUM_SRC] = '{0, 6, 5, 4, 3, 2, 1, 5, 6, 7, 4};

	// vector addresses per source
	localparam logic [15:0] SRC_VEC [NUM_SRC] = '{
		16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E,
		16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018
	};
	localparam logic [15:0] VEC_NMI = SRC_VEC[SRC_WDT];

endpackage

// ===== hw/irq_flag_bit.sv
// one sticky interrupt request flag
// assumes single-cycle pulses on request, write and acknowledge
`timescale 1ns/10ps
`default_nettype none
module irq_flag_bit
(
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic srcReq,
	input  wire logic swWrite,
	input  wire logic swData,
	input  wire logic ack,
	output var  logic flag_q
);

	logic flag_d;

	// set wins over write-zero and acknowledge, so no event is lost
	// pulse held until cleared
	always_comb
	begin
		flag_d = flag_q;
		if (swWrite)
			flag_d = swData;
		else if (ack)
			flag_d = 1'b0;
		if (srcReq)
			flag_d = 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end

endmodule
`default_nettype wire

// ===== hw/pin_edge_detect.sv
// edge detector for the external interrupt pin
// assumes the pin is already synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module pin_edge_detect
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       pinLevel,
	input  wire logic [1:0] edgeSel,
	output var  logic       edgeReq
);

	logic prev_q;
	logic primed_q;

	// primed_q hides the first sample so a high pin at reset is no edge
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			prev_q   <= 1'b0;
			primed_q <= 1'b0;
		end
		else
		begin
			prev_q   <= pinLevel;
			primed_q <= 1'b1;
		end
	end

	always_comb
	begin
		case (irq_ctrl_pkg::edge_sel_t'(edgeSel))
			irq_ctrl_pkg::EDGE_FALL: edgeReq = prev_q & ~pinLevel;
			irq_ctrl_pkg::EDGE_RISE: edgeReq = ~prev_q & pinLevel;
			irq_ctrl_pkg::EDGE_BOTH: edgeReq = prev_q ^ pinLevel;
			default:                 edgeReq = 1'b0;
		endcase
		edgeReq = edgeReq & primed_q;
	end

endmodule
`default_nettype wire

// ===== hw/vectored_irq_ctrl.sv
// vectored interrupt controller: a watchdog, non-maskable outside interval mode, and ten maskable
// sources, request and disable flag registers, fixed priority, vector out
// assumes a byte register port and a core that pulses ackStrobe once per
// taken request and drops its global enable after clearGlobalEnable_q
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module vectored_irq_ctrl
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wrData,
	input  wire logic        wrEn,
	input  wire logic        rdEn,
	output var  logic [7:0]  rdData_q,
	input  wire logic        wdtIntervalMode,
	input  wire logic        globalIrqEnable,
	input  wire logic        ackStrobe,
	input  wire logic        watchdog_overflow_req,
	input  wire logic        usb_timer_overflow_req,
	input  wire logic        usb_token_rx_end_req,
	input  wire logic        usb_data_rx_end_req,
	input  wire logic        usb_data_tx_end_req,
	input  wire logic        usb_resume_detect_req,
	input  wire logic        extPinLevel,
	input  wire logic        serial_xfer_end_req,
	input  wire logic        timer_a_match_req,
	input  wire logic        timer_b_match_req,
	input  wire logic        key_return_req,
	output var  logic        intRequest_q,
	output var  logic        intNmi_q,
	output var  logic [15:0] vector_q,
	output var  logic        clearGlobalEnable_q,
	output var  logic        standbyRelease_q
);

	localparam int N = irq_ctrl_pkg::NUM_SRC;

	logic [N-1:0]       srcReq;
	logic [N-1:0]       swWrite;
	logic [N-1:0]       swData;
	logic [N-1:0]       ackSrc;
	logic [N-1:0]       flag;
	logic [N-1:0]       disable_v;
	logic [N-1:0]       grantable;
	logic [7:0]         disLo_q;
	logic [7:0]         disHi_q;
	logic [1:0]         edgeSel_q;
	logic               nmiPend_q;
	logic [3:0]         selIdx_q;
	logic [3:0]         selIdx;
	logic               anyGrant;
	logic               pinEdge;
	logic               selOk;
	logic               ackTaken;
	logic [7:0]         pendLo;
	logic [7:0]         pendHi;

	////////////////////////////////////////////////////////////////////
	// sources

	// port-driven pin changes land here like any edge
	pin_edge_detect u_pin
	(
		.core_clk (core_clk),
		.nrst     (nrst),
		.pinLevel (extPinLevel),
		.edgeSel  (edgeSel_q),
		.edgeReq  (pinEdge)
	);

	// watchdog feeds the maskable slot only in interval mode
	assign srcReq = {key_return_req, timer_b_match_req, timer_a_match_req,
		serial_xfer_end_req, pinEdge, usb_resume_detect_req,
		usb_data_tx_end_req, usb_data_rx_end_req, usb_token_rx_end_req,
		usb_timer_overflow_req, watchdog_overflow_req & wdtIntervalMode};

	assign ackTaken = ackStrobe & intRequest_q;

	// software write and acknowledge decode per source
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			swWrite[i] = wrEn && (addr == (irq_ctrl_pkg::SRC_IN_HI[i] ?
				irq_ctrl_pkg::ADDR_PEND_HI : irq_ctrl_pkg::ADDR_PEND_LO));
			swData[i]  = wrData[irq_ctrl_pkg::SRC_POS[i]];
			ackSrc[i]  = ackTaken && !intNmi_q && (selIdx_q == 4'(i));
			disable_v[i] = irq_ctrl_pkg::SRC_IN_HI[i] ?
				disHi_q[irq_ctrl_pkg::SRC_POS[i]] :
				disLo_q[irq_ctrl_pkg::SRC_POS[i]];
		end
		// watchdog flag frozen outside interval mode
		swWrite[irq_ctrl_pkg::SRC_WDT] =
			swWrite[irq_ctrl_pkg::SRC_WDT] & wdtIntervalMode;
	end

	generate
		for (genvar g = 0; g < N; g++)
		begin : g_flag
			irq_flag_bit u_flag
			(
				.core_clk (core_clk),
				.nrst     (nrst),
				.srcReq   (srcReq[g]),
				.swWrite  (swWrite[g]),
				.swData   (swData[g]),
				.ack      (ackSrc[g]),
				.flag_q   (flag[g])
			);
		end
	endgenerate

	// non-maskable watchdog request, set wins over acknowledge
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			nmiPend_q <= 1'b0;
		else if (watchdog_overflow_req && !wdtIntervalMode)
			nmiPend_q <= 1'b1;
		else if (ackTaken && intNmi_q)
			nmiPend_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// control registers

	// masks start all ones; unused bits stay one
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			disLo_q <= irq_ctrl_pkg::DIS_RESET;
			disHi_q <= irq_ctrl_pkg::DIS_RESET;
		end
		else if (wrEn && addr == irq_ctrl_pkg::ADDR_DIS_LO)
			disLo_q <= wrData | ~irq_ctrl_pkg::LO_USED;
		else if (wrEn && addr == irq_ctrl_pkg::ADDR_DIS_HI)
			disHi_q <= wrData | ~irq_ctrl_pkg::HI_USED;
	end

	// edge select; the prohibited code simply detects nothing
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			edgeSel_q <= irq_ctrl_pkg::EDGE_RESET;
		else if (wrEn && addr == irq_ctrl_pkg::ADDR_EDGE_SEL)
			edgeSel_q <= wrData[irq_ctrl_pkg::EDGE_LSB +: 2];
	end

	// flag register images; unused bits read zero
	always_comb
	begin
		pendLo = irq_ctrl_pkg::PEND_RESET;
		pendHi = irq_ctrl_pkg::PEND_RESET;
		for (int i = 0; i < N; i++)
		begin
			if (irq_ctrl_pkg::SRC_IN_HI[i])
				pendHi[irq_ctrl_pkg::SRC_POS[i]] = flag[i];
			else
				pendLo[irq_ctrl_pkg::SRC_POS[i]] = flag[i];
		end
		pendLo[irq_ctrl_pkg::SRC_POS[irq_ctrl_pkg::SRC_WDT]] =
			flag[irq_ctrl_pkg::SRC_WDT] & wdtIntervalMode;
	end

	// read data one cycle after the strobe, zero if unmapped
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			rdData_q <= 8'h00;
		else if (rdEn)
		begin
			case (addr)
				irq_ctrl_pkg::ADDR_PEND_LO:  rdData_q <= pendLo;
				irq_ctrl_pkg::ADDR_PEND_HI:  rdData_q <= pendHi;
				irq_ctrl_pkg::ADDR_DIS_LO:   rdData_q <= disLo_q;
				irq_ctrl_pkg::ADDR_DIS_HI:   rdData_q <= disHi_q;
				irq_ctrl_pkg::ADDR_EDGE_SEL:
					rdData_q <= 8'(edgeSel_q) << irq_ctrl_pkg::EDGE_LSB;
				default:                     rdData_q <= 8'h00;
			endcase
		end
		else
			rdData_q <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////
	// resolution

	// flag, clear mask and global enable all needed
	// a set mask blocks service but not the flag
	assign grantable = flag & ~disable_v & {N{globalIrqEnable}};

	// mask and enable of the source being selected this cycle, kept as a
	// net so a check one cycle later sees the index that was registered
	assign selOk = !disable_v[selIdx] && globalIrqEnable;

	// lowest index wins by scanning downward
	always_comb
	begin
		selIdx   = 4'h0;
		anyGrant = 1'b0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (grantable[i])
			begin
				selIdx   = 4'(i);
				anyGrant = 1'b1;
			end
		end
	end

	// request to the core; two idle cycles after each acknowledge give
	// the core time to drop its enable before the next grant
	// non-maskable bypasses enable and priority
	// blocked flags simply stay and win later
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			intRequest_q <= 1'b0;
			intNmi_q     <= 1'b0;
			vector_q     <= 16'h0000;
			selIdx_q     <= 4'h0;
		end
		else if (ackTaken || clearGlobalEnable_q)
			intRequest_q <= 1'b0;
		else
		begin
			intRequest_q <= nmiPend_q | anyGrant;
			intNmi_q     <= nmiPend_q;
			selIdx_q     <= selIdx;
			vector_q     <= nmiPend_q ? irq_ctrl_pkg::VEC_NMI :
				irq_ctrl_pkg::SRC_VEC[selIdx];
		end
	end

	// each acknowledge tells the core to clear its enable
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			clearGlobalEnable_q <= 1'b0;
		else
			clearGlobalEnable_q <= ackTaken;
	end

	// wake a halted core on any unmasked or non-maskable request
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			standbyRelease_q <= 1'b0;
		else
			standbyRelease_q <= nmiPend_q | (|(flag & ~disable_v));
	end

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	nmi_first_a: assert property (
		nmiPend_q && !ackTaken && !clearGlobalEnable_q
		|=> intRequest_q && intNmi_q && vector_q == irq_ctrl_pkg::VEC_NMI)
		else $error("pending nmi not presented");

	standby_wake_a: assert property (
		$rose(nmiPend_q) |=> standbyRelease_q)
		else $error("no standby release for nmi");

	wdt_route_a: assert property (
		watchdog_overflow_req && !wdtIntervalMode
		|=> nmiPend_q && !flag[irq_ctrl_pkg::SRC_WDT] ||
			$past(flag[irq_ctrl_pkg::SRC_WDT]))
		else $error("watchdog routing wrong");

	fixed_priority_a: assert property (
		$rose(intRequest_q) && !intNmi_q
		|-> ($past(grantable) & ((11'h1 << selIdx_q) - 11'h1)) == 11'h0)
		else $error("higher priority source skipped");

	vector_map_a: assert property (
		intRequest_q && !intNmi_q
		|-> vector_q == irq_ctrl_pkg::VEC_NMI + {11'h0, selIdx_q, 1'b0})
		else $error("vector does not match source");

	flag_capture_a: assert property (
		serial_xfer_end_req |=> flag[irq_ctrl_pkg::SRC_SER] [*2])
		else $error("serial flag not held");

	ack_clear_a: assert property (
		ackTaken && !intNmi_q && !srcReq[selIdx_q] && !wrEn
		|=> !flag[$past(selIdx_q)] && !intRequest_q ##1 !intRequest_q)
		else $error("flag not cleared on acknowledge");

	mask_gate_a: assert property (
		$rose(intRequest_q) && !intNmi_q
		|-> $past(selOk))
		else $error("masked source granted");

	fixed_bits_a: assert property (
		(disLo_q & ~irq_ctrl_pkg::LO_USED) == ~irq_ctrl_pkg::LO_USED &&
		(disHi_q & ~irq_ctrl_pkg::HI_USED) == ~irq_ctrl_pkg::HI_USED)
		else $error("fixed mask bits lost");

	read_timing_a: assert property (
		rdEn && addr == irq_ctrl_pkg::ADDR_DIS_HI
		|=> rdData_q == $past(disHi_q))
		else $error("mask read data wrong");

	nmi_taken_c: cover property (ackTaken && intNmi_q);
	key_taken_c: cover property (ackTaken && selIdx_q == 4'hA && !intNmi_q);
	two_pending_c: cover property (grantable[1] && grantable[9]);

endmodule
`default_nettype wire

// ===== testbench/core_model.sv
// processor core model: takes each presented request once and keeps
// its own global enable bit, which the bench raises on demand
// assumes the controller drops intRequest_q for two cycles after an ack
`timescale 1ns/10ps
`default_nettype none
module core_model
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        eiReq,
	input  wire logic        intRequest_q,
	input  wire logic        intNmi_q,
	input  wire logic [15:0] vector_q,
	input  wire logic        clearGlobalEnable_q,
	output var  logic        ackStrobe,
	output var  logic        globalIrqEnable,
	output var  logic [15:0] takenVec,
	output var  logic        takenNmi,
	output var  int          takenCnt,
	output var  int          clearCnt
);
	////////////////////////////////////////////////////////////////////
	// one ack per presented request; the guard stops a second ack
	// landing on whatever source the controller shows next
	// enable dropped on ack
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			ackStrobe <= 1'b0;
			globalIrqEnable <= 1'b0;
			takenCnt <= 0;
			clearCnt <= 0;
		end
		else
		begin
			ackStrobe <= intRequest_q && !ackStrobe;
			if (intRequest_q && !ackStrobe)
			begin
				takenVec <= vector_q;
				takenNmi <= intNmi_q;
			end
			if (ackStrobe)
				takenCnt <= takenCnt + 1; // counted once the ack is seen
			if (ackStrobe)
				globalIrqEnable <= 1'b0;
			else if (eiReq)
				globalIrqEnable <= 1'b1;
			if (clearGlobalEnable_q)
				clearCnt <= clearCnt + 1;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/vectored_irq_ctrl_bench.sv
// self-checking bench for the vectored interrupt controller
// assumes the core model above sits on the core side of the block
`timescale 1ns/10ps
`default_nettype none
module vectored_irq_ctrl_bench;
	logic        core_clk, nrst, wrEn, rdEn, wdtMode, eiReq, pin;
	logic [15:0] addr;
	logic [7:0]  wrData;
	logic [10:0] src;
	logic [7:0]  rdData_q;
	logic        intRequest_q, intNmi_q, clearGlobalEnable_q;
	logic        standbyRelease_q, ackStrobe, globalIrqEnable, takenNmi;
	logic [15:0] vector_q, takenVec;
	int          takenCnt, clearCnt;
	int          nMismatch = 0;
	int          testsRun = 0;
	logic [15:0] vecTab [11] = '{16'h0004, 16'h0006, 16'h0008, 16'h000A,
		16'h000C, 16'h000E, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018};
	logic [3:0]  riseHit = 4'hA; // codes 01 and 11 see rising edges
	logic [3:0]  fallHit = 4'h9; // codes 00 and 11 see falling edges

	vectored_irq_ctrl u_vectored_irq_ctrl (.core_clk(core_clk), .nrst(nrst),
		.addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
		.rdData_q(rdData_q), .wdtIntervalMode(wdtMode),
		.globalIrqEnable(globalIrqEnable), .ackStrobe(ackStrobe),
		.watchdog_overflow_req(src[0]), .usb_timer_overflow_req(src[1]),
		.usb_token_rx_end_req(src[2]), .usb_data_rx_end_req(src[3]),
		.usb_data_tx_end_req(src[4]), .usb_resume_detect_req(src[5]),
		.extPinLevel(pin), .serial_xfer_end_req(src[7]),
		.timer_a_match_req(src[8]), .timer_b_match_req(src[9]),
		.key_return_req(src[10]), .intRequest_q(intRequest_q),
		.intNmi_q(intNmi_q), .vector_q(vector_q),
		.clearGlobalEnable_q(clearGlobalEnable_q),
		.standbyRelease_q(standbyRelease_q));

	core_model u_core_model (.core_clk(core_clk), .nrst(nrst), .eiReq(eiReq),
		.intRequest_q(intRequest_q), .intNmi_q(intNmi_q), .vector_q(vector_q),
		.clearGlobalEnable_q(clearGlobalEnable_q), .ackStrobe(ackStrobe),
		.globalIrqEnable(globalIrqEnable), .takenVec(takenVec),
		.takenNmi(takenNmi), .takenCnt(takenCnt), .clearCnt(clearCnt));

	////////////////////////////////////////////////////////////////////
	// 250 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// run span is under a thousand cycles; the 10000-cycle limit means a hang
	initial
	begin
		#40000;
		nMismatch++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		testsRun++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge core_clk);
		wrEn <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge core_clk);
		rdEn <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), 16'(exp), 16'(rdData_q));
	endtask

	task automatic pulse(input logic [10:0] m);
		@(posedge core_clk);
		src <= m;
		@(posedge core_clk);
		src <= 11'h000;
	endtask

	task automatic ei();
		@(posedge core_clk);
		eiReq <= 1'b1;
		@(posedge core_clk);
		eiReq <= 1'b0;
	endtask

	// bounded wait for the core model to take one request
	task automatic taken(input logic [15:0] vec, input logic nmi);
		int n;
		n = takenCnt;
		repeat (60) if (takenCnt == n) @(posedge core_clk);
		chk("vector", vec, takenVec);
		chk("nmi", 16'(nmi), 16'(takenNmi));
		repeat (2) @(posedge core_clk);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{nrst, wrEn, rdEn, eiReq, pin, addr, wrData, src} = '0;
		wdtMode = 1'b1;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		rd(16'hFFE0, 8'h00);
		rd(16'hFFE1, 8'h00);
		rd(16'hFFE4, 8'hFF);
		rd(16'hFFE5, 8'hFF);
		wr(16'hFFE2, 8'hFF);
		rd(16'hFFE2, 8'h00);
		// all sources pending at once, drained in priority order
		wr(16'hFFE4, 8'h00);
		rd(16'hFFE4, 8'h0C);
		wr(16'hFFE5, 8'h00);
		rd(16'hFFE5, 8'h83);
		wr(16'hFFE0, 8'hFF);
		wr(16'hFFE1, 8'hFF);
		rd(16'hFFE0, 8'hF3);
		rd(16'hFFE1, 8'h7C);
		chk("request", 16'h0, 16'(intRequest_q));
		chk("standby", 16'h1, 16'(standbyRelease_q));
		for (int i = 0; i < 11; i++)
		begin
			ei();
			taken(vecTab[i], 1'b0);
		end
		rd(16'hFFE0, 8'h00);
		rd(16'hFFE1, 8'h00);
		// masked event is recorded, then served once unmasked
		wr(16'hFFE4, 8'hFF);
		ei();
		// serial stays masked after the unmask below and keeps its flag
		pulse(11'h280);
		repeat (5) @(posedge core_clk);
		#1;
		chk("request", 16'h0, 16'(intRequest_q));
		chk("standby", 16'h0, 16'(standbyRelease_q));
		rd(16'hFFE0, 8'hA0);
		wr(16'hFFE4, 8'h7F);
		taken(16'h0016, 1'b0);
		// watchdog mode: flag bit hidden, overflow is non-maskable
		wdtMode <= 1'b0;
		wr(16'hFFE0, 8'hFF);
		rd(16'hFFE0, 8'hF2);
		wr(16'hFFE0, 8'h00);
		wr(16'hFFE4, 8'h00);
		pulse(11'h001);
		taken(16'h0004, 1'b1);
		ei();
		pulse(11'h401);
		taken(16'h0004, 1'b1);
		ei();
		taken(16'h0018, 1'b0);
		// pin edge codes; pin source masked before the pin moves
		wr(16'hFFE4, 8'hFF);
		for (int c = 0; c < 4; c++)
		begin
			wr(16'hFFEC, 8'(c << 2));
			wr(16'hFFE0, 8'h00);
			@(posedge core_clk);
			pin <= 1'b1;
			repeat (3) @(posedge core_clk);
			rd(16'hFFE0, {6'h00, riseHit[c], 1'b0});
			wr(16'hFFE0, 8'h00);
			@(posedge core_clk);
			pin <= 1'b0;
			repeat (3) @(posedge core_clk);
			rd(16'hFFE0, {6'h00, fallHit[c], 1'b0});
		end
		chk("clears", 16'(takenCnt), 16'(clearCnt));
		// eleven drained, timer b, two non-maskable and the key source
		chk("taken", 16'h000F, 16'(takenCnt));
		stop_test();
	end
endmodule
`default_nettype wire
